// >>> src/odtpd_pkg.sv
package odtpd_pkg;

  // ---------------------------------------------------------------
  // Clock and latencies
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS  = 20000;   // 50 MHz reference clock
  localparam int WRITE_LATENCY  = 5;       // Write latency in clock cycles
  localparam int LEAD_CK        = WRITE_LATENCY - 1;  // Termination lead interval
  localparam int SYNC_LAT_CK    = WRITE_LATENCY - 2;  // Sync on and off latency
  localparam int HIST_DEPTH     = LEAD_CK + 2;        // History length for look-back

  // ---------------------------------------------------------------
  // Delays in their own unit and derived cycle counts
  // ---------------------------------------------------------------
  localparam int CPDED_CK       = 1;       // Command pass to disable delay, clock cycles
  localparam int RFC_NS         = 110;     // Refresh cycle time, ns
  localparam int XPDLL_NS       = 24;      // Exit delay with locked DLL, ns
  localparam int RFC_CK   = (RFC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int XPDLL_CK = (XPDLL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ---------------------------------------------------------------
  // Analog termination change bounds, ps
  // ---------------------------------------------------------------
  localparam int AON_MIN_PS     = -400;    // Sync turn-on skew minimum
  localparam int AON_MAX_PS     = 400;     // Sync turn-on skew maximum
  localparam int AOF_MIN_PS     = 6000;    // Sync turn-off skew minimum
  localparam int AOF_MAX_PS     = 14000;   // Sync turn-off skew maximum
  localparam int AONPD_MIN_PS   = 2000;    // Async turn-on delay minimum
  localparam int AONPD_MAX_PS   = 8500;    // Async turn-on delay maximum
  localparam int AOFPD_MIN_PS   = 2000;    // Async turn-off delay minimum
  localparam int AOFPD_MAX_PS   = 8500;    // Async turn-off delay maximum
  localparam int SYNC_LAT_PS    = SYNC_LAT_CK * CLK_PERIOD_PS;

  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int CNT_W          = 8;       // Tail and refresh counter width
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CPDED_CNT = CNT_W'(CPDED_CK);
  localparam logic [CNT_W-1:0] RFC_CNT   = CNT_W'(RFC_CK);
  localparam logic [CNT_W-1:0] XPDLL_CNT = CNT_W'(XPDLL_CK);
  localparam logic [CNT_W-1:0] CNT_ONE   = 8'h01;
  localparam logic DLL_FROZEN_VAL = 1'b0;  // Mode bit value that freezes the DLL

  // Classification of one termination pin change
  typedef struct packed {
    logic uncertain;                       // Change fell in a transition period
    logic async_resp;                      // Change answered asynchronously
    logic sync_resp;                       // Change answered synchronously
  } odtpd_class_t;

  localparam odtpd_class_t CLASS_NONE = '{uncertain: 1'b0, async_resp: 1'b0, sync_resp: 1'b0};

endpackage

// >>> src/odtpd_top.sv
`timescale 1ns/10ps
// Operation
// - Lead interval is write latency minus one
// - Frozen DLL bit zero enables transition periods
// - Entry period: lead start to disable delay end
// - Pending refresh stretches entry period end
// - Lead start excluded, delay ends included
// - Turn-on change bounded by min/max of both
// - Turn-off change bounded by min/max of both
// - Sync latencies are write latency minus two
// - Exit period: lead before high to exit delay
// - Changes outside power-down answered synchronously
// - Changes inside power-down answered asynchronously when the DLL is frozen
// - Overlapping entry/exit periods merge into one
// - Overlapping exit/entry periods merge into one
// - Async path not delayed by additive latency
// - Termination receiver stays active in power-down
module odtpd_top
  import odtpd_pkg::*;
(
  input  wire logic         clk_in,            // 50 MHz clock
  input  wire logic         rstn_in,           // Sync reset, active low
  input  wire logic         cke_in,            // Clock enable pin
  input  wire logic         odt_in,            // Termination control pin
  input  wire logic         refresh_cmd_in,    // Refresh command registered
  input  wire logic         dll_freeze_sel_in, // Mode register zero freeze bit
  output logic              rtt_en_out,        // Internal termination enable
  output logic              async_mode_out,    // Async termination mode active
  output odtpd_class_t      odt_class_out      // Classification, lead plus one cycles late
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [HIST_DEPTH-1:0] cke_hist_r,  cke_hist_nxt;   // Registered clock enable history
  logic [HIST_DEPTH-1:0] odt_hist_r,  odt_hist_nxt;   // Registered termination history
  logic [LEAD_CK-1:0]    tail_hist_r, tail_hist_nxt;  // Delayed tail activity
  logic [CNT_W-1:0]      tail_cnt_r,  tail_cnt_nxt;   // Remaining tail of a period
  logic [CNT_W-1:0]      rfc_cnt_r,   rfc_cnt_nxt;    // Remaining refresh time
  logic                  async_r,     async_nxt;      // Async mode state
  logic                  rtt_r,       rtt_nxt;        // Termination enable
  odtpd_class_t          class_r,     class_nxt;      // Change classification
  logic                  frozen;                      // DLL frozen in power-down
  logic                  cke_fall;                    // Clock enable first low
  logic                  cke_rise;                    // Clock enable first high
  logic                  look_edge;                   // Edge ahead of delayed point
  logic                  in_window;                   // Delayed point in a period
  logic                  odt_chg_d;                   // Pin change at delayed point

  // Worst-case termination change bounds inside a transition period
  localparam int ON_EARLY_PS  = (SYNC_LAT_PS + AON_MIN_PS < AONPD_MIN_PS) ?
                                (SYNC_LAT_PS + AON_MIN_PS) : AONPD_MIN_PS;
  localparam int ON_LATE_PS   = (SYNC_LAT_PS + AON_MAX_PS > AONPD_MAX_PS) ?
                                (SYNC_LAT_PS + AON_MAX_PS) : AONPD_MAX_PS;
  localparam int OFF_EARLY_PS = (SYNC_LAT_PS + AOF_MIN_PS < AOFPD_MIN_PS) ?
                                (SYNC_LAT_PS + AOF_MIN_PS) : AOFPD_MIN_PS;
  localparam int OFF_LATE_PS  = (SYNC_LAT_PS + AOF_MAX_PS > AOFPD_MAX_PS) ?
                                (SYNC_LAT_PS + AOF_MAX_PS) : AOFPD_MAX_PS;

  // ---------------------------------------------------------------
  // Event decode
  // ---------------------------------------------------------------
  // Edges of the registered clock enable and mode bit decode
  always_comb begin
    frozen   = (dll_freeze_sel_in == DLL_FROZEN_VAL);
    cke_fall = !cke_hist_r[0] && cke_hist_r[1];
    cke_rise = cke_hist_r[0] && !cke_hist_r[1];
  end

  // ---------------------------------------------------------------
  // History and tail counters
  // ---------------------------------------------------------------
  // Next values for histories and period tails
  always_comb begin
    cke_hist_nxt  = {cke_hist_r[HIST_DEPTH-2:0], cke_in};
    odt_hist_nxt  = {odt_hist_r[HIST_DEPTH-2:0], odt_in};
    tail_hist_nxt = {tail_hist_r[LEAD_CK-2:0], (tail_cnt_r != CNT_ZERO)};
    rfc_cnt_nxt   = rfc_cnt_r;
    tail_cnt_nxt  = tail_cnt_r;
    // Refresh time counter
    if (refresh_cmd_in) begin
      rfc_cnt_nxt = RFC_CNT;
    end else if (rfc_cnt_r != CNT_ZERO) begin
      rfc_cnt_nxt = rfc_cnt_r - CNT_ONE;
    end
    // Tail after entry or exit edge, end point included
    if (frozen && cke_fall) begin
      if (rfc_cnt_r > CPDED_CNT) begin
        tail_cnt_nxt = rfc_cnt_r;
      end else begin
        tail_cnt_nxt = CPDED_CNT;
      end
    end else if (frozen && cke_rise) begin
      tail_cnt_nxt = XPDLL_CNT;
    end else if (tail_cnt_r != CNT_ZERO) begin
      tail_cnt_nxt = tail_cnt_r - CNT_ONE;
    end
  end

  // Register histories and counters
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cke_hist_r  <= '0;
      odt_hist_r  <= '0;
      tail_hist_r <= '0;
      tail_cnt_r  <= CNT_ZERO;
      rfc_cnt_r   <= CNT_ZERO;
    end else begin
      cke_hist_r  <= cke_hist_nxt;
      odt_hist_r  <= odt_hist_nxt;
      tail_hist_r <= tail_hist_nxt;
      tail_cnt_r  <= tail_cnt_nxt;
      rfc_cnt_r   <= rfc_cnt_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Transition window at the delayed point
  // ---------------------------------------------------------------
  // A clock enable edge less than a lead interval ahead puts the point in a period
  always_comb begin
    look_edge = 1'b0;
    for (int i = 1; i <= LEAD_CK; i++) begin
      if (cke_hist_r[i] != cke_hist_r[i+1]) begin
        look_edge = 1'b1;
      end
    end
    // Union of overlapping entry and exit periods
    in_window = frozen && (look_edge || tail_hist_r[LEAD_CK-1]);
    odt_chg_d = odt_hist_r[LEAD_CK] != odt_hist_r[LEAD_CK+1];
  end

  // ---------------------------------------------------------------
  // Mode, termination and classification
  // ---------------------------------------------------------------
  // Next mode, termination level and classification
  always_comb begin
    async_nxt = async_r;
    class_nxt = CLASS_NONE;
    // Async once entry period is over, sync again at first high
    if (!frozen || cke_hist_r[0]) begin
      async_nxt = 1'b0;
    end else if (tail_cnt_r == CNT_ZERO && !cke_fall) begin
      async_nxt = 1'b1;
    end
    // Async follows the pin directly, sync after the fixed latency
    if (async_r) begin
      rtt_nxt = odt_hist_r[0];
    end else begin
      // The output flop supplies the last cycle of the sync latency
      rtt_nxt = odt_hist_r[SYNC_LAT_CK-1];
    end
    // Classify the change at the delayed point
    if (odt_chg_d) begin
      if (in_window) begin
        class_nxt.uncertain = 1'b1;
      end else if (frozen && !cke_hist_r[LEAD_CK]) begin
        class_nxt.async_resp = 1'b1;
      end else begin
        class_nxt.sync_resp = 1'b1;
      end
    end
  end

  // Register mode, termination and classification
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      async_r <= 1'b0;
      rtt_r   <= 1'b0;
      class_r <= CLASS_NONE;
    end else begin
      async_r <= async_nxt;
      rtt_r   <= rtt_nxt;
      class_r <= class_nxt;
    end
  end

  assign rtt_en_out     = rtt_r;
  assign async_mode_out = async_r;
  assign odt_class_out  = class_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  chk_async_direct_path: assert property (async_r |=> rtt_r == $past(odt_hist_r[0]))
    else $error("async termination not taken from pin directly");
  chk_sync_latency_path: assert property (!async_r |=> rtt_r == $past(odt_in, 4))
    else $error("sync termination latency wrong");
  chk_entry_tail_len: assert property (frozen && cke_fall && rfc_cnt_r <= CPDED_CNT
      |=> tail_cnt_r == CPDED_CNT)
    else $error("entry tail not set to disable delay");
  chk_refresh_tail_len: assert property (frozen && cke_fall && rfc_cnt_r > CPDED_CNT
      |=> tail_cnt_r == $past(rfc_cnt_r))
    else $error("entry tail ignores pending refresh");
  chk_exit_tail_len: assert property (frozen && cke_rise |=> tail_cnt_r == XPDLL_CNT)
    else $error("exit tail not set to exit delay");
  chk_sync_when_high: assert property (cke_hist_r[0] |=> !async_r)
    else $error("async mode while clock enable high");
  chk_async_in_pd: assert property (frozen && !cke_hist_r[0] && !cke_fall
      && tail_cnt_r == CNT_ZERO && $stable(dll_freeze_sel_in) |=> async_r)
    else $error("async mode not entered in power-down");
  chk_no_async_thawed: assert property (!frozen ##1 !frozen |-> !async_r)
    else $error("async mode without frozen DLL");
  chk_window_uncertain: assert property (frozen && odt_chg_d && look_edge
      |=> class_r.uncertain && !class_r.sync_resp)
    else $error("change near edge not marked uncertain");
  chk_class_onehot: assert property ($onehot0(class_r))
    else $error("more than one classification bit");

  cov_entry_uncertain: cover property (cke_fall ##[1:8] class_r.uncertain);
  cov_async_change: cover property (class_r.async_resp);
  cov_sync_after_exit: cover property (cke_rise ##[1:16] class_r.sync_resp);
  cov_refresh_entry: cover property (frozen && cke_fall && rfc_cnt_r > CPDED_CNT);

endmodule

// >>> bench/odtpd_ctrl_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Controller side: clock enable, termination and refresh pins
// ---------------------------------------------------------------
module odtpd_ctrl_model (
  input  wire logic clk_in,             // Device clock
  output logic      cke_out,            // Clock enable pin
  output logic      odt_out,            // Termination pin
  output logic      refresh_out,        // Refresh command pulse
  output logic      dll_freeze_sel_out  // Freeze select bit
);
  // Idle levels before the first edge
  initial begin
    cke_out            = 1'b1;
    odt_out            = 1'b0;
    refresh_out        = 1'b0;
    dll_freeze_sel_out = 1'b0;
  end

  // Mode bit is only changed under reset
  task automatic set_mode(input logic sel);
    dll_freeze_sel_out = sel;
  endtask

  // Present pins for exactly one sampling edge, then move off it
  task automatic step(input logic cke, input logic odt, input logic rfr);
    cke_out     = cke;
    odt_out     = odt;
    refresh_out = rfr & cke;
    @(posedge clk_in);
    #2;
  endtask
endmodule

// >>> bench/tb.sv
`timescale 1ns/10ps
module tb
  import odtpd_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam logic [7:0] C_SYNC = 8'h01;  // Synchronous class
  localparam logic [7:0] C_ASYN = 8'h02;  // Asynchronous class
  localparam logic [7:0] C_UNC  = 8'h04;  // Uncertain class
  logic         clk_in;                   // Bench clock
  logic         rstn_in;                  // Sync reset
  logic         cke;                      // Clock enable pin
  logic         odt;                      // Termination pin
  logic         rfr;                      // Refresh pulse
  logic         dsel;                     // Freeze select
  logic         rtt_en_out;               // Termination enable
  logic         async_mode_out;           // Async mode flag
  odtpd_class_t odt_class_out;            // Change class pulse
  int           failures;                 // Mismatch count
  int           tests_run;                // Comparison count
  int           cyc;                      // Watchdog cycles

  odtpd_ctrl_model u_ctrl (
    .clk_in             (clk_in),
    .cke_out            (cke),
    .odt_out            (odt),
    .refresh_out        (rfr),
    .dll_freeze_sel_out (dsel)
  );

  odtpd_top uut (
    .clk_in            (clk_in),
    .rstn_in           (rstn_in),
    .cke_in            (cke),
    .odt_in            (odt),
    .refresh_cmd_in    (rfr),
    .dll_freeze_sel_in (dsel),
    .rtt_en_out        (rtt_en_out),
    .async_mode_out    (async_mode_out),
    .odt_class_out     (odt_class_out)
  );

  // ---------------------------------------------------------------
  // Clock, watchdog and helpers
  // ---------------------------------------------------------------
  initial begin
    clk_in  = 1'b0;
    rstn_in = 1'b0;
    cyc     = 0;
  end
  always #10 clk_in = ~clk_in;

  // Cuts a hung run short
  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 3000) begin
      failures++;
      final_report();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hold(input logic c, input logic o, input int n);
    repeat (n) u_ctrl.step(c, o, 1'b0);
  endtask

  task automatic do_reset(input logic sel);
    rstn_in = 1'b0;
    u_ctrl.set_mode(sel);
    hold(1'b1, 1'b0, 3);
    rstn_in = 1'b1;
    hold(1'b1, 1'b0, 12);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic sc_sync();
    u_ctrl.step(1'b1, 1'b1, 1'b0);
    hold(1'b1, 1'b1, 2);
    chk(8'(rtt_en_out), 8'h00);
    u_ctrl.step(1'b1, 1'b1, 1'b0);
    chk(8'(rtt_en_out), 8'h01);
    hold(1'b1, 1'b1, 2);
    chk(8'(odt_class_out), C_SYNC);
    $display("sync response done");
  endtask

  task automatic sc_powerdown();
    hold(1'b1, 1'b0, 2);
    hold(1'b0, 1'b0, 4);
    chk(8'(odt_class_out), C_UNC);
    hold(1'b0, 1'b0, 3);
    chk(8'(async_mode_out), 8'h01);
    u_ctrl.step(1'b0, 1'b1, 1'b0);
    chk(8'(rtt_en_out), 8'h00);
    u_ctrl.step(1'b0, 1'b1, 1'b0);
    chk(8'(rtt_en_out), 8'h01);
    hold(1'b0, 1'b1, 4);
    chk(8'(odt_class_out), C_ASYN);
    hold(1'b1, 1'b1, 3);
    chk(8'(async_mode_out), 8'h00);
    hold(1'b1, 1'b1, 6);
    hold(1'b1, 1'b0, 4);
    chk(8'(rtt_en_out), 8'h00);
    hold(1'b1, 1'b0, 2);
    chk(8'(odt_class_out), C_SYNC);
    $display("power-down entry and exit done");
  endtask

  task automatic sc_refresh();
    u_ctrl.step(1'b1, 1'b0, 1'b1);
    hold(1'b0, 1'b0, 3);
    hold(1'b0, 1'b1, 6);
    chk(8'(odt_class_out), C_UNC);
    hold(1'b1, 1'b1, 12);
    $display("refresh stretch done");
  endtask

  task automatic sc_overlap();
    u_ctrl.step(1'b0, 1'b1, 1'b0);
    u_ctrl.step(1'b0, 1'b0, 1'b0);
    hold(1'b1, 1'b0, 5);
    chk(8'(odt_class_out), C_UNC);
    hold(1'b1, 1'b0, 12);
    // Short idle: exit period runs into the next entry period
    hold(1'b0, 1'b0, 10);
    u_ctrl.step(1'b1, 1'b0, 1'b0);
    u_ctrl.step(1'b0, 1'b1, 1'b0);
    hold(1'b0, 1'b1, 5);
    chk(8'(odt_class_out), C_UNC);
    hold(1'b1, 1'b0, 12);
    $display("short power-down done");
  endtask

  task automatic sc_no_freeze();
    do_reset(1'b1);
    hold(1'b0, 1'b0, 9);
    chk(8'(async_mode_out), 8'h00);
    hold(1'b0, 1'b1, 3);
    chk(8'(rtt_en_out), 8'h00);
    u_ctrl.step(1'b0, 1'b1, 1'b0);
    chk(8'(rtt_en_out), 8'h01);
    hold(1'b1, 1'b1, 8);
    $display("unfrozen mode done");
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    failures  = 0;
    tests_run = 0;
    do_reset(1'b0);
    sc_sync();
    sc_powerdown();
    sc_refresh();
    sc_overlap();
    sc_no_freeze();
    final_report();
  end
endmodule
